//--- rtl/btg_buffer.sv
/*
  two-entry buffer with valid and ready on both sides; assumes one clock,
  a synchronous-release active-low reset and a clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
module btg_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // honest full and empty flags
  assign in_ready = (count_reg != 2'(DEPTH));
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + 2'(push) - 2'(pop);
    end
  end

  // storage, written only on a taken word
  always_ff @(posedge clk) begin
    if (ce && push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule
`default_nettype wire

//--- rtl/btg_consts.svh
/*
  register offsets, field positions, reset values and fixed figures of the
  tone generator; assumes inclusion by bare name from design files.
*/
`ifndef BTG_CONSTS_SVH
`define BTG_CONSTS_SVH

// register offsets on the control port
`define BTG_OFS_LEFT_CTRL 7'h47
`define BTG_OFS_RIGHT_CTRL 7'h48
`define BTG_OFS_LEN_HIGH 7'h49
`define BTG_OFS_LEN_MID 7'h4A
`define BTG_OFS_LEN_LOW 7'h4B
`define BTG_OFS_SIN_HIGH 7'h4C
`define BTG_OFS_SIN_LOW 7'h4D
`define BTG_OFS_COS_HIGH 7'h4E
`define BTG_OFS_COS_LOW 7'h4F

// field positions
`define BTG_EN_BIT 7
`define BTG_RSVD_BIT 6
`define BTG_LINK_HI 7
`define BTG_LINK_LO 6
`define BTG_VOL_HI 5
`define BTG_VOL_LO 0

// reset values
`define BTG_RST_LEFT_CTRL 8'h00
`define BTG_RST_RIGHT_CTRL 8'h00
`define BTG_RST_LEN_HIGH 8'h00
`define BTG_RST_LEN_MID 8'h00
`define BTG_RST_LEN_LOW 8'hEE
`define BTG_RST_SIN_HIGH 8'h10
`define BTG_RST_SIN_LOW 8'hD8
`define BTG_RST_COS_HIGH 8'h7E
`define BTG_RST_COS_LOW 8'hE3

// processing configuration that carries the tone
`define BTG_TONE_CFG 5'h19

// oscillator start amplitude, leaves headroom for the +2 dB setting
`define BTG_OSC_AMPL 16'h6000

// gain mantissas, 2.14 fixed point, for +2 dB down to -3 dB
`define BTG_MANT_0 16'h5092
`define BTG_MANT_1 16'h47CF
`define BTG_MANT_2 16'h4000
`define BTG_MANT_3 16'h390A
`define BTG_MANT_4 16'h32D6
`define BTG_MANT_5 16'h2D4F
`define BTG_MANT_FRAC 14

`endif

//--- rtl/btg_pkg.sv
/*
  types shared by the tone generator files; assumes nothing beyond a
  SystemVerilog compiler.
*/
package btg_pkg;
  typedef enum logic {BTG_IDLE, BTG_RUN} btg_state_type;
  typedef logic [7:0] btg_byte_type;
  typedef logic signed [15:0] btg_sample_type;
endpackage

//--- rtl/btg_top.sv
/*
  tone generator for the stereo playback path: control registers, run
  length counter, recursive sine oscillator, per-channel volume and an
  output buffer. assumes SAMPLE_TICK pulses once per DAC sample period,
  synchronous to CLK, and that the control port is driven synchronously.
*/
// Summary of operation
// - enable bit starts tone, clears itself after
// - left volume code 0 +2 dB, -1 dB/step
// - right volume uses the same dB encoding
// - link field: 01 left=right, 10 right=left
// - exactly programmed sample count produced, then stop
// - 24-bit length from three bytes, reset 0x0000EE
// - 16-bit sine coefficient, reset bytes 0x10, 0xD8
// - one tone sample per DAC sample period
// - tone only in processing configuration 25
// - 16-bit cosine coefficient, reset bytes 0x7E, 0xE3
`timescale 1ns/10ps
`default_nettype none
`include "btg_consts.svh"
module btg_top (
  // clock, reset, clock enable
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // control register port
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WR,
  input wire btg_pkg::btg_byte_type REG_WDATA,
  output logic [7:0] REG_RDATA,
  // playback path context
  input wire logic SAMPLE_TICK,
  input wire logic [4:0] PROC_CFG,
  // tone sample stream
  output logic TONE_VALID,
  input wire logic TONE_READY,
  output logic [15:0] TONE_LEFT,
  output logic [15:0] TONE_RIGHT,
  // status
  output logic TONE_ACTIVE
);
  import btg_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  btg_state_type state_reg;
  btg_state_type state_next;
  logic rsvd_reg;
  logic [5:0] left_vol_reg;
  logic [7:0] right_ctrl_reg;
  logic [7:0] len_high_reg;
  logic [7:0] len_mid_reg;
  logic [7:0] len_low_reg;
  logic [7:0] sin_high_reg;
  logic [7:0] sin_low_reg;
  logic [7:0] cos_high_reg;
  logic [7:0] cos_low_reg;
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic pend_reg;
  logic pend_next;
  btg_sample_type osc_x_reg;
  btg_sample_type osc_y_reg;
  logic [7:0] rdata_reg;
  logic buf_in_ready;
  logic [31:0] buf_out_data;

  // volume code to linear gain: mantissa per dB in a 6 dB octave, then shift
  function automatic btg_sample_type btg_scale(input btg_sample_type smp, input logic [5:0] code);
    logic [5:0] step;
    logic [5:0] octave;
    logic signed [15:0] mant;
    logic signed [31:0] prod;
    logic signed [31:0] shifted;
    step = code % 6'h6;
    octave = code / 6'h6;
    case (step)
      6'h0: mant = `BTG_MANT_0;
      6'h1: mant = `BTG_MANT_1;
      6'h2: mant = `BTG_MANT_2;
      6'h3: mant = `BTG_MANT_3;
      6'h4: mant = `BTG_MANT_4;
      default: mant = `BTG_MANT_5;
    endcase
    prod = smp * mant;
    shifted = prod >>> (`BTG_MANT_FRAC + 32'(octave));
    return shifted[15:0];
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // write decode
  wire wr_left = REG_WR & (REG_ADDR == `BTG_OFS_LEFT_CTRL);
  wire wr_right = REG_WR & (REG_ADDR == `BTG_OFS_RIGHT_CTRL);
  wire wr_len_h = REG_WR & (REG_ADDR == `BTG_OFS_LEN_HIGH);
  wire wr_len_m = REG_WR & (REG_ADDR == `BTG_OFS_LEN_MID);
  wire wr_len_l = REG_WR & (REG_ADDR == `BTG_OFS_LEN_LOW);
  wire wr_sin_h = REG_WR & (REG_ADDR == `BTG_OFS_SIN_HIGH);
  wire wr_sin_l = REG_WR & (REG_ADDR == `BTG_OFS_SIN_LOW);
  wire wr_cos_h = REG_WR & (REG_ADDR == `BTG_OFS_COS_HIGH);
  wire wr_cos_l = REG_WR & (REG_ADDR == `BTG_OFS_COS_LOW);

  // assembled length and coefficients
  wire [23:0] length_val = {len_high_reg, len_mid_reg, len_low_reg};
  wire signed [15:0] sin_coef = {sin_high_reg, sin_low_reg};
  wire signed [15:0] cos_coef = {cos_high_reg, cos_low_reg};

  // run control terms
  wire running = (state_reg == BTG_RUN);
  wire cfg_ok = (PROC_CFG == `BTG_TONE_CFG);
  wire start = wr_left & REG_WDATA[`BTG_EN_BIT] & ~running;
  wire step = running & cfg_ok & (SAMPLE_TICK | pend_reg) & (cnt_reg != 24'h0) & buf_in_ready;
  wire last = step & (cnt_reg == 24'h1);
  wire empty_run = running & (cnt_reg == 24'h0);

  // volume source selection
  wire [1:0] link = right_ctrl_reg[`BTG_LINK_HI:`BTG_LINK_LO];
  wire [5:0] right_vol = right_ctrl_reg[`BTG_VOL_HI:`BTG_VOL_LO];
  wire [5:0] left_eff = (link == 2'h1) ? right_vol : left_vol_reg;
  wire [5:0] right_eff = (link == 2'h2) ? left_vol_reg : right_vol;

  // oscillator rotation: x' = c x - s y, y' = s x + c y
  wire signed [31:0] p_cx = cos_coef * osc_x_reg;
  wire signed [31:0] p_sy = sin_coef * osc_y_reg;
  wire signed [31:0] p_sx = sin_coef * osc_x_reg;
  wire signed [31:0] p_cy = cos_coef * osc_y_reg;
  wire signed [32:0] sum_x = 33'(p_cx) - 33'(p_sy);
  wire signed [32:0] sum_y = 33'(p_sx) + 33'(p_cy);
  wire signed [15:0] x_rot = sum_x[30:15];
  wire signed [15:0] y_rot = sum_y[30:15];

  // scaled channel samples
  wire signed [15:0] left_smp = btg_scale(osc_y_reg, left_eff);
  wire signed [15:0] right_smp = btg_scale(osc_y_reg, right_eff);

  // state, counter and pending tick
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    case (state_reg)
      BTG_IDLE: begin
        pend_next = 1'b0;
        if (start) begin
          state_next = BTG_RUN;
          cnt_next = length_val;
        end
      end
      BTG_RUN: begin
        if (step) begin
          cnt_next = cnt_reg - 24'h1;
          pend_next = 1'b0;
        end else if (SAMPLE_TICK && cfg_ok) begin
          pend_next = 1'b1;
        end
        // a software write in the same cycle wins over the self-clear
        if (wr_left && !REG_WDATA[`BTG_EN_BIT]) begin
          state_next = BTG_IDLE;
        end else if ((last || empty_run) && !wr_left) begin
          state_next = BTG_IDLE;
        end
      end
      default: begin
        state_next = BTG_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= BTG_IDLE;
      cnt_reg <= 24'h0;
      pend_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end

  // oscillator state, restarted at each start
  always_ff @(posedge CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      osc_x_reg <= `BTG_OSC_AMPL;
      osc_y_reg <= 16'h0000;
    end else if (CE) begin
      if (start) begin
        osc_x_reg <= `BTG_OSC_AMPL;
        osc_y_reg <= 16'h0000;
      end else if (step) begin
        osc_x_reg <= x_rot;
        osc_y_reg <= y_rot;
      end
    end
  end

  // configuration registers
  always_ff @(posedge CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rsvd_reg <= 1'(`BTG_RST_LEFT_CTRL >> `BTG_RSVD_BIT);
      left_vol_reg <= 6'h00;
      right_ctrl_reg <= `BTG_RST_RIGHT_CTRL;
      len_high_reg <= `BTG_RST_LEN_HIGH;
      len_mid_reg <= `BTG_RST_LEN_MID;
      len_low_reg <= `BTG_RST_LEN_LOW;
      sin_high_reg <= `BTG_RST_SIN_HIGH;
      sin_low_reg <= `BTG_RST_SIN_LOW;
      cos_high_reg <= `BTG_RST_COS_HIGH;
      cos_low_reg <= `BTG_RST_COS_LOW;
    end else if (CE) begin
      if (wr_left) begin
        rsvd_reg <= REG_WDATA[`BTG_RSVD_BIT];
        left_vol_reg <= REG_WDATA[`BTG_VOL_HI:`BTG_VOL_LO];
      end
      if (wr_right) right_ctrl_reg <= REG_WDATA;
      if (wr_len_h) len_high_reg <= REG_WDATA;
      if (wr_len_m) len_mid_reg <= REG_WDATA;
      if (wr_len_l) len_low_reg <= REG_WDATA;
      if (wr_sin_h) sin_high_reg <= REG_WDATA;
      if (wr_sin_l) sin_low_reg <= REG_WDATA;
      if (wr_cos_h) cos_high_reg <= REG_WDATA;
      if (wr_cos_l) cos_low_reg <= REG_WDATA;
    end
  end

  // read selection, enable bit shows the live run state
  wire [7:0] left_read = {running, rsvd_reg, left_vol_reg};
  wire [7:0] rd_mux =
    (REG_ADDR == `BTG_OFS_LEFT_CTRL) ? left_read :
    (REG_ADDR == `BTG_OFS_RIGHT_CTRL) ? right_ctrl_reg :
    (REG_ADDR == `BTG_OFS_LEN_HIGH) ? len_high_reg :
    (REG_ADDR == `BTG_OFS_LEN_MID) ? len_mid_reg :
    (REG_ADDR == `BTG_OFS_LEN_LOW) ? len_low_reg :
    (REG_ADDR == `BTG_OFS_SIN_HIGH) ? sin_high_reg :
    (REG_ADDR == `BTG_OFS_SIN_LOW) ? sin_low_reg :
    (REG_ADDR == `BTG_OFS_COS_HIGH) ? cos_high_reg :
    (REG_ADDR == `BTG_OFS_COS_LOW) ? cos_low_reg : 8'h00;

  // registered read data
  always_ff @(posedge CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_reg <= 8'h00;
    end else if (CE) begin
      rdata_reg <= rd_mux;
    end
  end

  // output buffer, a stalled receiver holds the generator back
  btg_buffer #(
    .WIDTH(32),
    .DEPTH(2)
  ) btg_buffer_inst (
    .clk(CLK),
    .rst_n(rst_sync_reg),
    .ce(CE),
    .in_valid(step),
    .in_ready(buf_in_ready),
    .in_data({left_smp, right_smp}),
    .out_valid(TONE_VALID),
    .out_ready(TONE_READY),
    .out_data(buf_out_data)
  );

  // outputs
  assign TONE_LEFT = buf_out_data[31:16];
  assign TONE_RIGHT = buf_out_data[15:0];
  assign REG_RDATA = rdata_reg;
  assign TONE_ACTIVE = running;
endmodule
`default_nettype wire

//--- test/btg_dac_sink.sv
/*
  playback path model taking tone words.
  assumes the bench raises stall to ask for random back-pressure.
*/
`timescale 1ns/10ps
`default_nettype none
module btg_dac_sink (
  // clock
  input wire logic clk,
  input wire logic ce,
  // back-pressure request
  input wire logic stall,
  // tone stream
  input wire logic valid,
  output logic ready,
  input wire logic [15:0] left,
  input wire logic [15:0] right
);
  int seed = 74;
  int n_words = 0;
  logic [31:0] words [0:63];
  // ready moves after the falling edge only
  initial ready = 1'b1;
  always @(negedge clk) ready <= stall ? ($random(seed) % 3 == 0) : 1'b1;
  // one word per handshake, left and right of one step
  always @(posedge clk) if (valid && ready && ce) begin
    words[n_words % 64] <= {left, right};
    n_words <= n_words + 1;
  end
endmodule
`default_nettype wire

//--- test/btg_top_chk.sv
/*
  port checker for the tone generator.
  assumes binding to btg_top from the bench top file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "btg_consts.svh"
module btg_top_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // control port
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WR,
  input wire btg_pkg::btg_byte_type REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // playback context and stream
  input wire logic SAMPLE_TICK,
  input wire logic [4:0] PROC_CFG,
  input wire logic TONE_VALID,
  input wire logic TONE_READY,
  input wire logic [15:0] TONE_LEFT,
  input wire logic [15:0] TONE_RIGHT,
  input wire logic TONE_ACTIVE
);
  import btg_pkg::*;
  // address decode
  wire ctl_sel = REG_ADDR == `BTG_OFS_LEFT_CTRL;
  wire mapped = REG_ADDR >= `BTG_OFS_LEFT_CTRL && REG_ADDR <= `BTG_OFS_COS_LOW;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // register port
  AST_RD_UNMAPPED: assert property (CE && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_ENABLE: assert property (CE && ctl_sel && !REG_WR |=> REG_RDATA[7] == $past(TONE_ACTIVE))
    else $error("enable readback differs from active");
  AST_SINE_BACK: assert property (CE && REG_WR && REG_ADDR == `BTG_OFS_SIN_LOW ##1
    CE && !REG_WR && REG_ADDR == `BTG_OFS_SIN_LOW |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("sine low byte readback wrong");
  // run control
  AST_START: assert property (CE && REG_WR && ctl_sel && REG_WDATA[7] |=> TONE_ACTIVE)
    else $error("enable write did not start");
  AST_STOP: assert property (CE && REG_WR && ctl_sel && !REG_WDATA[7] |=> !TONE_ACTIVE)
    else $error("disable write did not stop");
  AST_IDLE_QUIET: assert property (!TONE_ACTIVE && !TONE_VALID |=> !TONE_VALID)
    else $error("sample while idle");
  AST_CFG_GATE: assert property (!TONE_VALID && PROC_CFG != `BTG_TONE_CFG |=> !TONE_VALID)
    else $error("sample outside tone configuration");
  AST_RISE_TICK: assert property ($rose(TONE_VALID) |-> $past(SAMPLE_TICK) && $past(CE))
    else $error("sample without strobe");
  // stream
  AST_STALL_HOLD: assert property (TONE_VALID && !(TONE_READY && CE) |=>
    TONE_VALID && $stable(TONE_LEFT) && $stable(TONE_RIGHT))
    else $error("word changed under stall");
endmodule
`default_nettype wire

//--- test/btg_top_tb.sv
/*
  self-checking bench for the tone generator.
  assumes the sink model and checker files compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "btg_consts.svh"
module btg_top_tb;
  import btg_pkg::*;
  logic clk, arst_n, ce, reg_wr, tick, tick_en, stall;
  logic [6:0] reg_addr;
  btg_byte_type reg_wdata;
  logic [7:0] reg_rdata, d;
  logic [4:0] proc_cfg;
  logic tone_valid, tone_ready, tone_active;
  logic [15:0] tone_left, tone_right;
  logic [31:0] w;
  int error_cnt = 0, n_tests = 0, seed = 74, i, k, n, cnt;
  logic [6:0] ofs [9] = '{7'h47, 7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4C, 7'h4D, 7'h4E, 7'h4F};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE, 8'h10, 8'hD8, 8'h7E, 8'hE3};
  btg_top btg_top_inst (.CLK(clk), .ARST_N(arst_n), .CE(ce), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_TICK(tick), .PROC_CFG(proc_cfg),
    .TONE_VALID(tone_valid), .TONE_READY(tone_ready), .TONE_LEFT(tone_left),
    .TONE_RIGHT(tone_right), .TONE_ACTIVE(tone_active));
  btg_dac_sink btg_dac_sink_inst (.clk(clk), .ce(ce), .stall(stall), .valid(tone_valid),
    .ready(tone_ready), .left(tone_left), .right(tone_right));
  // clock and sample strobe
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) tick <= tick_en && !tick && ($random(seed) % 4 == 0);
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(string what, logic [6:0] a, logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk(what, e, reg_rdata);
  endtask
  // one tone burst of n samples, left code lc
  task automatic run(int len, logic [5:0] lc);
    logic [23:0] l;
    l = len[23:0];
    cnt = btg_dac_sink_inst.n_words;
    wr(`BTG_OFS_LEN_HIGH, l[23:16]);
    wr(`BTG_OFS_LEN_MID, l[15:8]);
    wr(`BTG_OFS_LEN_LOW, l[7:0]);
    tick_en = 1'b1;
    wr(`BTG_OFS_LEFT_CTRL, {1'b1, 1'b0, lc});
    chk("active", 1, tone_active);
    for (k = 0; k < 3000 && tone_active === 1'b1; k++) @(negedge clk);
    tick_en = 1'b0;
    for (k = 0; k < 200 && tone_valid !== 1'b0; k++) @(negedge clk);
    chk("words", len, btg_dac_sink_inst.n_words - cnt);
    chk("self clear", 0, tone_active);
  endtask
  // expected second sample for code 2 (0 dB) or 8 (-6 dB)
  function automatic logic near(int c, logic [15:0] g);
    int y;
    y = (int'(`BTG_OSC_AMPL) * 32'sh10D8) >>> 15;
    if (c == 8) y = y >>> 1;
    return (int'($signed(g)) - y) inside {[-2:2]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    proc_cfg = `BTG_TONE_CFG;
    tick_en = 1'b0;
    stall = 1'b0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 9; i++) rc("reset value", ofs[i], rv[i]);
    wr(7'h50, 8'h5A);
    rc("unmapped high", 7'h50, 8'h00);
    rc("unmapped low", 7'h46, 8'h00);
    $display("test reset and map done");
    for (i = 1; i < 9; i++) begin
      d = $random(seed);
      wr(ofs[i], d);
      rc("readback", ofs[i], d);
    end
    wr(`BTG_OFS_RIGHT_CTRL, 8'h00);
    $display("test readback done");
    for (i = 0; i < 6; i++) begin
      stall = i[0];
      n = (i < 2) ? i : 2 + {$random(seed)} % 39;
      run(n, 6'h00);
    end
    $display("test burst length done");
    proc_cfg = 5'h18;
    cnt = btg_dac_sink_inst.n_words;
    wr(`BTG_OFS_LEN_LOW, 8'h03);
    tick_en = 1'b1;
    wr(`BTG_OFS_LEFT_CTRL, 8'h80);
    repeat (60) @(negedge clk);
    chk("gated words", 0, btg_dac_sink_inst.n_words - cnt);
    chk("gated active", 1, tone_active);
    wr(`BTG_OFS_LEFT_CTRL, 8'h00);
    chk("stop", 0, tone_active);
    tick_en = 1'b0;
    proc_cfg = `BTG_TONE_CFG;
    $display("test configuration gate done");
    wr(`BTG_OFS_SIN_HIGH, 8'h10);
    wr(`BTG_OFS_SIN_LOW, 8'hD8);
    for (i = 0; i < 4; i++) begin
      stall = i[0];
      wr(`BTG_OFS_RIGHT_CTRL, {i[1:0], 6'h08});
      run(2, 6'h02);
      w = btg_dac_sink_inst.words[cnt % 64];
      chk("first sample", 0, w);
      w = btg_dac_sink_inst.words[(cnt + 1) % 64];
      chk("left level", 1, near(i == 1 ? 8 : 2, w[31:16]));
      chk("right level", 1, near(i == 2 ? 2 : 8, w[15:0]));
    end
    $display("test volume and link done");
    test_done();
  end
endmodule
bind btg_top btg_top_chk btg_top_chk_inst (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_TICK(SAMPLE_TICK),
  .PROC_CFG(PROC_CFG), .TONE_VALID(TONE_VALID), .TONE_READY(TONE_READY), .TONE_LEFT(TONE_LEFT),
  .TONE_RIGHT(TONE_RIGHT), .TONE_ACTIVE(TONE_ACTIVE));
`default_nettype wire
